// [hw/ucopt_uart.sv]
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`include "ucopt_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module ucopt_uart #(
  parameter int DIV_W = 16
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial pins: transmit as output and enable, receive as input, output and enable.
  output logic             txPinOut,
  output logic             txPinOe,
  input  wire logic        rxPinIn,
  output logic             rxPinOut,
  output logic             rxPinOe,
  // System side.
  input  wire logic        uartClkStopped,
  output logic             wakeReq,
  output logic             irqReq
);
  // The divider register is sixteen bits, so a narrower counter would wrap.
  if (DIV_W < 16) begin : g_div_chk
    $error("DIV_W must be at least 16");
  end
  // -------------------------------------------------------------------------
  // Registers.
  // -------------------------------------------------------------------------
  ucopt_pkg::ucopt_ctrl_a_s ctrlA_r;
  ucopt_pkg::ucopt_ctrl_b_s ctrlB_r;
  ucopt_pkg::ucopt_stat_s   stat_r;
  logic                     singleWire_r;
  logic [15:0]              div_r;
  logic [7:0]               rxData_r;
  logic [2:0]               rxCount_r;
  logic                     ack_r;
  logic                     wrA;
  logic                     wrB;
  logic                     uartOff;
  logic                     txActive;
  logic                     rxActive;
  logic                     txLine;
  logic                     rxLine;
  logic                     dataWr;
  logic                     dataRd;
  logic                     rxDone;
  logic                     rxKeep;
  logic                     rxFrameErr;
  logic                     rxParErr;
  logic                     rxNinth;
  logic [7:0]               rxByte;
  logic                     txLoad;

  // One wait state: the answer comes on the second edge of a request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ack_r <= 1'b0;
    else     ack_r <= (read | write) & ~ack_r;
  end
  assign waitrequest = (read | write) & ~ack_r;
  assign wrA    = write & ack_r & (address == `UCOPT_OFS_CTRL_A);
  assign wrB    = write & ack_r & (address == `UCOPT_OFS_CTRL_B);
  assign dataWr = write & ack_r & (address == `UCOPT_OFS_DATA);
  assign dataRd = read & ack_r & (address == `UCOPT_OFS_DATA);
  assign uartOff = ~ctrlA_r.uartOn;
  assign txActive = ctrlA_r.uartOn & ctrlB_r.txOn;
  assign rxActive = ctrlA_r.uartOn & ctrlB_r.rxOn;

  // Read data register; the transmit ninth bit always reads zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else begin
      case (address)
        `UCOPT_OFS_STATUS:  readdata <= {24'h0, stat_r};
        `UCOPT_OFS_CTRL_A:  readdata <= {24'h0, ctrlA_r[7:1], 1'b0};
        `UCOPT_OFS_CTRL_B:  readdata <= {24'h0, ctrlB_r};
        `UCOPT_OFS_CTRL_C:  readdata <= {31'h0, singleWire_r};
        `UCOPT_OFS_DATA:    readdata <= {24'h0, rxData_r};
        `UCOPT_OFS_DIV_HI:  readdata <= {24'h0, div_r[15:8]};
        `UCOPT_OFS_DIV_LO:  readdata <= {24'h0, div_r[7:0]};
        `UCOPT_OFS_RXCOUNT: readdata <= {29'h0, rxCount_r};
        default:            readdata <= 32'h0000_0000;
      endcase
    end
  end

  // First control register; the received ninth bit is hardware owned.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlA_r <= `UCOPT_CTRL_A_RST;
    end else begin
      if (wrA) begin
        ctrlA_r.uartOn        <= writedata[7];
        ctrlA_r.wordLengthSel <= writedata[6];
        ctrlA_r.parityOn      <= writedata[5];
        ctrlA_r.parityKind    <= ucopt_pkg::ucopt_par_e'(writedata[4:3]);
        ctrlA_r.sendBreak     <= writedata[2] & writedata[7];
        ctrlA_r.txNinthBit    <= writedata[0];
      end else if (uartOff) begin
        ctrlA_r.sendBreak <= 1'b0;
      end
      if (rxDone & rxKeep & ~stat_r.rxAvailFlag & ctrlA_r.wordLengthSel
          & ~ctrlA_r.parityOn) ctrlA_r.rxNinthBit <= rxNinth;
    end
  end

  // Second control register; disabling clears only the two enables.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlB_r <= `UCOPT_CTRL_B_RST;
    end else if (wrB) begin
      ctrlB_r <= writedata[7:0];
      if (uartOff) begin
        ctrlB_r.txOn <= 1'b0;
        ctrlB_r.rxOn <= 1'b0;
      end
    end else if (uartOff) begin
      ctrlB_r.txOn <= 1'b0;
      ctrlB_r.rxOn <= 1'b0;
    end
  end

  // Divider and single wire select survive a disable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r        <= `UCOPT_DIV_RST;
      singleWire_r <= 1'b0;
    end else begin
      if (write & ack_r & (address == `UCOPT_OFS_DIV_HI)) div_r[15:8] <= writedata[7:0];
      if (write & ack_r & (address == `UCOPT_OFS_DIV_LO)) div_r[7:0] <= writedata[7:0];
      if (write & ack_r & (address == `UCOPT_OFS_CTRL_C)) singleWire_r <= writedata[0];
    end
  end

  // -------------------------------------------------------------------------
  // Pin synchroniser and pin drive.
  // -------------------------------------------------------------------------
  logic rxMeta_r;
  logic rxSync_r;
  logic rxPrev_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= rxPinIn;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end
  assign rxLine = rxSync_r;

  // In single wire mode the shared pin transmits only without the receiver.
  assign txPinOe  = txActive & ~singleWire_r;
  assign txPinOut = txLine;
  assign rxPinOe  = txActive & singleWire_r & ~ctrlB_r.rxOn;
  assign rxPinOut = txLine;

  // Wake request only while the UART clock is stopped.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wakeReq <= 1'b0;
    else     wakeReq <= uartClkStopped & ctrlB_r.wake & rxPrev_r & ~rxSync_r;
  end

  // -------------------------------------------------------------------------
  // Baud tick: divider counter restarts on disable.
  // -------------------------------------------------------------------------
  logic [DIV_W-1:0] baudCnt_r;
  logic             tick;
  assign tick = (baudCnt_r == DIV_W'(0));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) baudCnt_r <= '0;
    else if (uartOff) baudCnt_r <= DIV_W'(div_r) - DIV_W'(1);
    else if (tick) baudCnt_r <= DIV_W'(div_r) - DIV_W'(1);
    else baudCnt_r <= baudCnt_r - DIV_W'(1);
  end

  // -------------------------------------------------------------------------
  // Transmitter.
  // -------------------------------------------------------------------------
  ucopt_pkg::ucopt_tx_e txState_r;
  logic [8:0]           txShift_r;
  logic [8:0]           txHold_r;
  logic                 txFull_r;
  logic [4:0]           txBits_r;
  logic                 txPar;
  logic [3:0]           nBits;
  assign nBits = ctrlA_r.wordLengthSel ? 4'd9 : 4'd8;

  // Parity over the data bits below the parity position.
  always_comb begin
    txPar = 1'b0;
    case (ctrlA_r.parityKind)
      ucopt_pkg::PAR_EVEN:  txPar = ^(ctrlA_r.wordLengthSel ? txHold_r[7:0] : {1'b0, txHold_r[6:0]});
      ucopt_pkg::PAR_ODD:   txPar = ~^(ctrlA_r.wordLengthSel ? txHold_r[7:0] : {1'b0, txHold_r[6:0]});
      ucopt_pkg::PAR_MARK:  txPar = 1'b1;
      ucopt_pkg::PAR_SPACE: txPar = 1'b0;
      default:              txPar = 1'b0;
    endcase
  end

  assign txLoad = (txState_r == ucopt_pkg::TX_IDLE) & txFull_r & tick;

  // Holding buffer; it is emptied whenever the transmitter is off.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txHold_r <= 9'h000;
      txFull_r <= 1'b0;
    end else if (~txActive) begin
      txFull_r <= 1'b0;
    end else if (dataWr) begin
      txHold_r <= {ctrlA_r.txNinthBit, writedata[7:0]};
      txFull_r <= 1'b1;
    end else if (txLoad) begin
      txFull_r <= 1'b0;
    end
  end

  // Frame sequencer: start, data, two stop bits, then break if asked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState_r <= ucopt_pkg::TX_IDLE;
      txShift_r <= 9'h1ff;
      txBits_r  <= 5'd0;
    end else if (~txActive) begin
      txState_r <= ucopt_pkg::TX_IDLE;
      txShift_r <= 9'h1ff;
    end else if (tick) begin
      case (txState_r)
        ucopt_pkg::TX_IDLE: begin
          if (txFull_r) begin
            txShift_r <= txHold_r;
            if (ctrlA_r.parityOn) begin
              if (ctrlA_r.wordLengthSel) txShift_r[8] <= txPar;
              else txShift_r[7] <= txPar;
            end
            txState_r <= ucopt_pkg::TX_START;
          end else if (ctrlA_r.sendBreak) begin
            txBits_r  <= `UCOPT_BREAK_BITS;
            txState_r <= ucopt_pkg::TX_BREAK;
          end
        end
        ucopt_pkg::TX_START: begin
          txBits_r  <= {1'b0, nBits};
          txState_r <= ucopt_pkg::TX_DATA;
        end
        ucopt_pkg::TX_DATA: begin
          txShift_r <= {1'b1, txShift_r[8:1]};
          if (txBits_r == 5'd1) begin
            txBits_r  <= {3'b000, `UCOPT_TX_STOP_BITS};
            txState_r <= ucopt_pkg::TX_STOP;
          end else txBits_r <= txBits_r - 5'd1;
        end
        ucopt_pkg::TX_STOP: begin
          if (txBits_r == 5'd1) txState_r <= ucopt_pkg::TX_IDLE;
          else txBits_r <= txBits_r - 5'd1;
        end
        ucopt_pkg::TX_BREAK: begin
          if (txBits_r > 5'd1) txBits_r <= txBits_r - 5'd1;
          else if (~ctrlA_r.sendBreak) txState_r <= ucopt_pkg::TX_IDLE;
        end
        default: txState_r <= ucopt_pkg::TX_IDLE;
      endcase
    end
  end
  assign txLine = (txState_r == ucopt_pkg::TX_START) ? 1'b0 :
                  (txState_r == ucopt_pkg::TX_BREAK) ? 1'b0 :
                  (txState_r == ucopt_pkg::TX_DATA) ? txShift_r[0] : 1'b1;

  // -------------------------------------------------------------------------
  // Receiver, sampling each bit at mid point.
  // -------------------------------------------------------------------------
  ucopt_pkg::ucopt_rx_e rxState_r;
  logic [DIV_W-1:0]     rx_fifo_count_r;
  logic [3:0]           rxBits_r;
  logic [8:0]           rxShift_r;
  logic [1:0]           rxStops_r;
  logic                 rxSample;
  logic                 rxParCalc;
  assign rxSample = (rx_fifo_count_r == DIV_W'(0));
  assign rxNinth  = rxShift_r[8];
  assign rxByte   = ctrlA_r.wordLengthSel ? rxShift_r[7:0] : rxShift_r[8:1];
  assign rxDone   = rxSample & (rxState_r == ucopt_pkg::RX_STOP)
                    & (rxStops_r == 2'd1);
  assign rxFrameErr = ~rxLine;
  // Address bit lives at the top of the word; it is the parity position too.
  assign rxKeep = ~ctrlB_r.addrDetectOn | rxShift_r[8];
  always_comb begin
    rxParCalc = 1'b0;
    case (ctrlA_r.parityKind)
      ucopt_pkg::PAR_EVEN:  rxParCalc = ctrlA_r.wordLengthSel ? ^rxShift_r[7:0] : ^rxShift_r[7:1];
      ucopt_pkg::PAR_ODD:   rxParCalc = ctrlA_r.wordLengthSel ? ~^rxShift_r[7:0] : ~^rxShift_r[7:1];
      ucopt_pkg::PAR_MARK:  rxParCalc = 1'b1;
      ucopt_pkg::PAR_SPACE: rxParCalc = 1'b0;
      default:              rxParCalc = 1'b0;
    endcase
  end
  assign rxParErr = ctrlA_r.parityOn & (rxParCalc != rxShift_r[8]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxState_r <= ucopt_pkg::RX_IDLE;
      rx_fifo_count_r   <= '0;
      rxBits_r  <= 4'd0;
      rxShift_r <= 9'h000;
      rxStops_r <= 2'd0;
    end else if (~rxActive) begin
      rxState_r <= ucopt_pkg::RX_IDLE;
    end else begin
      rx_fifo_count_r <= rxSample ? DIV_W'(div_r) - DIV_W'(1) : rx_fifo_count_r - DIV_W'(1);
      case (rxState_r)
        ucopt_pkg::RX_IDLE: if (rxPrev_r & ~rxLine) begin
          rx_fifo_count_r   <= DIV_W'(div_r >> 1);
          rxState_r <= ucopt_pkg::RX_START;
        end
        ucopt_pkg::RX_START: if (rxSample) begin
          rxBits_r  <= nBits;
          rxState_r <= rxLine ? ucopt_pkg::RX_IDLE : ucopt_pkg::RX_DATA;
        end
        ucopt_pkg::RX_DATA: if (rxSample) begin
          rxShift_r <= {rxLine, rxShift_r[8:1]};
          if (rxBits_r == 4'd1) begin
            rxStops_r <= ctrlB_r.rxStopCount ? 2'd2 : 2'd1;
            rxState_r <= ucopt_pkg::RX_STOP;
          end else rxBits_r <= rxBits_r - 4'd1;
        end
        ucopt_pkg::RX_STOP: if (rxSample) begin
          if (rxStops_r == 2'd1) rxState_r <= ucopt_pkg::RX_IDLE;
          else rxStops_r <= rxStops_r - 2'd1;
        end
        default: rxState_r <= ucopt_pkg::RX_IDLE;
      endcase
    end
  end

  // Received data word and count; parity bit is not kept as data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxData_r  <= 8'h00;
      rxCount_r <= 3'd0;
    end else if (~rxActive) begin
      rxCount_r <= 3'd0;
    end else if (rxDone & rxKeep & ~stat_r.rxAvailFlag) begin
      rxData_r  <= (ctrlA_r.parityOn & ~ctrlA_r.wordLengthSel) ? {1'b0, rxByte[6:0]} : rxByte;
      rxCount_r <= 3'd1;
    end else if (dataRd) begin
      rxCount_r <= 3'd0;
    end
  end

  // Status flags; a hardware set wins over a software clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= `UCOPT_STAT_RST;
    end else if (uartOff) begin
      stat_r <= `UCOPT_STAT_RST;
    end else begin
      stat_r.txEmptyFlag <= ~txFull_r | txLoad;
      stat_r.txIdleFlag  <= (txState_r == ucopt_pkg::TX_IDLE) & ~txFull_r;
      stat_r.rxIdleFlag  <= (rxState_r == ucopt_pkg::RX_IDLE);
      if (rxDone & rxKeep) begin
        if (stat_r.rxAvailFlag) stat_r.overrunFlag <= 1'b1;
        else begin
          stat_r.rxAvailFlag   <= 1'b1;
          stat_r.framingFlag   <= rxFrameErr;
          stat_r.parityErrFlag <= rxParErr;
        end
      end else if (dataRd) begin
        stat_r.rxAvailFlag   <= 1'b0;
        stat_r.overrunFlag   <= 1'b0;
        stat_r.framingFlag   <= 1'b0;
        stat_r.parityErrFlag <= 1'b0;
        stat_r.noiseFlag     <= 1'b0;
      end
    end
  end

  // Interrupt request follows the flags, so it holds until they clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irqReq <= 1'b0;
    else irqReq <= (ctrlB_r.rxIrqOn & (stat_r.overrunFlag | stat_r.rxAvailFlag))
                 | (ctrlB_r.txIdleIrqOn & stat_r.txIdleFlag)
                 | (ctrlB_r.txEmptyIrqOn & stat_r.txEmptyFlag);
  end

  // -------------------------------------------------------------------------
  // Checks.
  // -------------------------------------------------------------------------
  chk_off_floats: assert property (@(posedge clk) disable iff (rst)
    uartOff |-> ~txPinOe & ~rxPinOe) else $error("pin driven while off");
  chk_tx_gate: assert property (@(posedge clk) disable iff (rst)
    txPinOe |-> ctrlA_r.uartOn & ctrlB_r.txOn) else $error("tx without enables");
  chk_off_clears: assert property (@(posedge clk) disable iff (rst)
    uartOff |=> ~ctrlB_r.txOn & ~ctrlB_r.rxOn & stat_r.txIdleFlag)
    else $error("disable did not clear");
  chk_rx_abort: assert property (@(posedge clk) disable iff (rst)
    ~rxActive |=> rxState_r == ucopt_pkg::RX_IDLE) else $error("rx not aborted");
  chk_tx_abort: assert property (@(posedge clk) disable iff (rst)
    ~txActive |=> (txState_r == ucopt_pkg::TX_IDLE) & ~txFull_r)
    else $error("tx not aborted");
  chk_wake_gate: assert property (@(posedge clk) disable iff (rst)
    wakeReq |-> $past(uartClkStopped) & $past(ctrlB_r.wake))
    else $error("wake without stopped clock");
  chk_rx_irq: assert property (@(posedge clk) disable iff (rst)
    ctrlB_r.rxIrqOn & stat_r.rxAvailFlag |=> irqReq) else $error("rx irq missing");
  chk_idle_irq: assert property (@(posedge clk) disable iff (rst)
    ctrlB_r.txIdleIrqOn & stat_r.txIdleFlag |=> irqReq) else $error("idle irq missing");
  chk_empty_irq: assert property (@(posedge clk) disable iff (rst)
    ctrlB_r.txEmptyIrqOn & stat_r.txEmptyFlag |=> irqReq) else $error("empty irq missing");
  chk_brk_low: assert property (@(posedge clk) disable iff (rst)
    txState_r == ucopt_pkg::TX_BREAK |-> ~txLine) else $error("break not low");
endmodule : ucopt_uart
`default_nettype wire

// [hw/ucopt_consts.svh]
`ifndef UCOPT_CONSTS_SVH
`define UCOPT_CONSTS_SVH
// ---------------------------------------------------------------------------
// Register word addresses (word offsets, one aligned 32-bit word each).
// ---------------------------------------------------------------------------
`define UCOPT_ADDR_W        4
`define UCOPT_OFS_STATUS    4'h0
`define UCOPT_OFS_CTRL_A    4'h1
`define UCOPT_OFS_CTRL_B    4'h2
`define UCOPT_OFS_CTRL_C    4'h3
`define UCOPT_OFS_DATA      4'h4
`define UCOPT_OFS_DIV_HI    4'h5
`define UCOPT_OFS_DIV_LO    4'h6
`define UCOPT_OFS_RXCOUNT   4'h7
// ---------------------------------------------------------------------------
// Reset values and frame constants.
// ---------------------------------------------------------------------------
`define UCOPT_CTRL_A_RST    8'h00
`define UCOPT_CTRL_B_RST    8'h00
`define UCOPT_STAT_RST      8'h0b
`define UCOPT_DIV_RST       16'h0010
`define UCOPT_DIV_MIN       16'h0010
`define UCOPT_BREAK_BITS    5'h0d
`define UCOPT_TX_STOP_BITS  2'h2
`endif

// [hw/ucopt_pkg.sv]
package ucopt_pkg;
  typedef enum logic [1:0] {
    PAR_EVEN  = 2'b00,
    PAR_ODD   = 2'b01,
    PAR_MARK  = 2'b10,
    PAR_SPACE = 2'b11
  } ucopt_par_e;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_STOP  = 3'b011,
    TX_BREAK = 3'b100
  } ucopt_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ucopt_rx_e;

  // First control register.
  typedef struct packed {
    logic       uartOn;
    logic       wordLengthSel;
    logic       parityOn;
    ucopt_par_e parityKind;
    logic       sendBreak;
    logic       rxNinthBit;
    logic       txNinthBit;
  } ucopt_ctrl_a_s;

  // Second control register.
  typedef struct packed {
    logic txOn;
    logic rxOn;
    logic rxStopCount;
    logic addrDetectOn;
    logic wake;
    logic rxIrqOn;
    logic txIdleIrqOn;
    logic txEmptyIrqOn;
  } ucopt_ctrl_b_s;

  // Status flags.
  typedef struct packed {
    logic parityErrFlag;
    logic noiseFlag;
    logic framingFlag;
    logic overrunFlag;
    logic rxIdleFlag;
    logic rxAvailFlag;
    logic txIdleFlag;
    logic txEmptyFlag;
  } ucopt_stat_s;
endpackage : ucopt_pkg

// [dv/ucopt_remote.sv]
`timescale 1ns/10ps
`default_nettype none
module ucopt_remote #(
  parameter int BIT_T = 16
) (
  // Clock.
  input  wire logic clk,
  // Line from the block, line to the block.
  input  wire logic lineIn,
  output logic      lineOut
);
  // The remote line idles high between frames.
  initial lineOut = 1'h1;

  // Bits go out LSB first, each held for one bit time.
  task automatic send_frame(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (BIT_T) @(posedge clk);
    end
    lineOut <= 1'h1;
  endtask : send_frame

  // Sampling mid-bit keeps a late start a few cycles off the bit edges.
  task automatic grab_frame(input int n, output logic [11:0] bits);
    bits = 12'h0;
    while (lineIn !== 1'h0) @(posedge clk);
    repeat (BIT_T / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = lineIn;
      repeat (BIT_T) @(posedge clk);
    end
  endtask : grab_frame
endmodule : ucopt_remote
`default_nettype wire

// [dv/uart_control_options_tb.sv]
`include "ucopt_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module uart_control_options_tb;
  // ----------------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------------
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest, txPinOut, txPinOe, rxPinOut, rxPinOe;
  logic        uartClkStopped = 1'h0;
  logic        wakeReq, irqReq, remLine;
  logic        wakeSeen = 1'h0;
  int          mismatches = 0;
  int          checks = 0;
  logic [11:0] q, frm;
  // A released tx pin reads high, as a pulled-up idle line would; a released rx pin reads the remote line.
  wire logic   txLine = txPinOe ? txPinOut : 1'h1;
  wire logic   rxLine = rxPinOe ? rxPinOut : remLine;

  // Clock, and a sticky catch of the one-cycle wake pulse.
  always #2 clk = ~clk;
  always @(posedge clk) if (wakeReq === 1'h1) wakeSeen <= 1'h1;

  ucopt_uart u_ucopt_uart (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .txPinOut(txPinOut),
    .txPinOe(txPinOe), .rxPinIn(rxLine), .rxPinOut(rxPinOut),
    .rxPinOe(rxPinOe), .uartClkStopped(uartClkStopped),
    .wakeReq(wakeReq), .irqReq(irqReq));
  ucopt_remote u_ucopt_remote (.clk(clk), .lineIn(txLine),
    .lineOut(remLine));

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] got,
                       input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Request held until waitrequest is sampled low; read data taken there.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [11:0] r);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'h0) @(posedge clk);
    r = readdata[11:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask : bus

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_reset();
    bus(0, `UCOPT_OFS_STATUS, 8'h0, q); check("status", q, 12'h00b);
    bus(0, `UCOPT_OFS_CTRL_B, 8'h0, q); check("ctrl_b", q, 12'h000);
    bus(0, 4'h8, 8'h0, q); check("unmapped", q, 12'h000);
    check("oe", {txPinOe, rxPinOe}, 12'h000);
    $display("test reset done");
  endtask : t_reset

  // Every parity kind over one word; the parity replaces bit seven.
  task automatic t_tx();
    logic p;
    bus(1, `UCOPT_OFS_CTRL_A, 8'h80, q);
    bus(1, `UCOPT_OFS_CTRL_B, 8'h80, q);
    for (int k = 0; k < 4; k++) begin
      p = (k == 0) ? ^7'h35 : (k == 1) ? ~^7'h35 : (k == 2);
      bus(1, `UCOPT_OFS_CTRL_A, 8'ha0 | 8'(k << 3), q);
      bus(1, `UCOPT_OFS_DATA, 8'h35, q);
      u_ucopt_remote.grab_frame(11, frm);
      check("txframe", frm, {3'h3, p, 7'h35, 1'h0});
    end
    $display("test tx done");
  endtask : t_tx

  // Data word dropped, address word kept and raising the request.
  task automatic t_rx();
    bus(1, `UCOPT_OFS_CTRL_A, 8'hc0, q);
    bus(1, `UCOPT_OFS_CTRL_B, 8'h54, q);
    u_ucopt_remote.send_frame({2'h1, 1'h0, 8'h5a, 1'h0}, 11);
    repeat (20) @(posedge clk);
    bus(0, `UCOPT_OFS_STATUS, 8'h0, q); check("drop", q & 12'h4, 12'h0);
    check("irqdrop", irqReq, 12'h0);
    u_ucopt_remote.send_frame({2'h1, 1'h1, 8'ha5, 1'h0}, 11);
    repeat (20) @(posedge clk);
    bus(0, `UCOPT_OFS_STATUS, 8'h0, q); check("avail", q & 12'h4, 12'h4);
    check("irq", irqReq, 12'h1);
    bus(0, `UCOPT_OFS_CTRL_A, 8'h0, q); check("ninth", q & 12'h2, 12'h2);
    bus(0, `UCOPT_OFS_DATA, 8'h0, q); check("rxdata", q, 12'h0a5);
    repeat (3) @(posedge clk);
    check("irqclr", irqReq, 12'h0);
    $display("test rx done");
  endtask : t_rx

  task automatic t_break();
    int n;
    n = 0;
    bus(1, `UCOPT_OFS_CTRL_B, 8'h80, q);
    bus(1, `UCOPT_OFS_CTRL_A, 8'h84, q);
    repeat (16) @(posedge clk);
    repeat (208) begin
      @(posedge clk);
      if (txLine !== 1'h0) n++;
    end
    check("breaklow", 12'(n), 12'h0);
    bus(1, `UCOPT_OFS_CTRL_A, 8'h80, q);
    repeat (48) @(posedge clk);
    check("breakend", txLine, 12'h1);
    $display("test break done");
  endtask : t_break

  // Switching off in mid-frame must abort and keep the configuration.
  task automatic t_off();
    bus(1, `UCOPT_OFS_CTRL_A, 8'hb9, q);
    bus(1, `UCOPT_OFS_CTRL_B, 8'hd7, q);
    bus(1, `UCOPT_OFS_DATA, 8'h35, q);
    repeat (40) @(posedge clk);
    bus(1, `UCOPT_OFS_CTRL_A, 8'h39, q);
    @(posedge clk);
    check("oeoff", {txPinOe, rxPinOe}, 12'h0);
    bus(0, `UCOPT_OFS_STATUS, 8'h0, q); check("stoff", q, 12'h00b);
    // The received ninth bit keeps the address bit taken earlier.
    bus(0, `UCOPT_OFS_CTRL_A, 8'h0, q); check("aoff", q, 12'h03a);
    bus(0, `UCOPT_OFS_CTRL_B, 8'h0, q); check("boff", q, 12'h017);
    bus(0, `UCOPT_OFS_RXCOUNT, 8'h0, q); check("cnt", q, 12'h0);
    $display("test off done");
  endtask : t_off

  // Single wire: the shared pin transmits only while the receiver is off.
  task automatic t_wire();
    bus(1, `UCOPT_OFS_CTRL_C, 8'h01, q);
    bus(1, `UCOPT_OFS_CTRL_A, 8'h80, q);
    bus(1, `UCOPT_OFS_CTRL_B, 8'h80, q);
    @(posedge clk);
    check("wiretx", {txPinOe, rxPinOe}, 12'h1);
    bus(1, `UCOPT_OFS_CTRL_B, 8'hc0, q);
    @(posedge clk);
    check("wirerx", {txPinOe, rxPinOe}, 12'h0);
    bus(1, `UCOPT_OFS_CTRL_C, 8'h00, q);
    $display("test wire done");
  endtask : t_wire

  // Only a stopped clock with the wake bit set may wake.
  task automatic t_wake();
    bus(1, `UCOPT_OFS_CTRL_A, 8'h80, q);
    for (int i = 0; i < 3; i++) begin
      bus(1, `UCOPT_OFS_CTRL_B, (i != 2) ? 8'h08 : 8'h00, q);
      uartClkStopped <= (i != 1);
      wakeSeen <= 1'h0;
      @(posedge clk);
      u_ucopt_remote.send_frame(12'h0, 1);
      repeat (8) @(posedge clk);
      check("wake", wakeSeen, 12'(i == 0));
    end
    uartClkStopped <= 1'h0;
    $display("test wake done");
  endtask : t_wake

  // Main sequence, and a watchdog against a hang.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_tx();
    t_rx();
    t_break();
    t_off();
    t_wire();
    t_wake();
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : uart_control_options_tb
`default_nettype wire
